// ===== pkg/pqm_consts.vh
// Purpose: constants for the power quality monitor
// Assumes: included by bare name from src
// Notes: register offsets are word indices; byte address is index*4
`ifndef PQM_CONSTS_VH
`define PQM_CONSTS_VH

// Register word indices
`define IDX_STATUS_FIRST  16'he502
`define IDX_STATUS_SECOND 16'he503
`define IDX_OI_THR        16'he507
`define IDX_OV_THR        16'he508
`define IDX_SAG_LEVEL     16'he509
`define IDX_IRQ_EN_FIRST  16'he50a
`define IDX_IRQ_EN_SECOND 16'he50b
`define IDX_DELAY_FIRST   16'he601
`define IDX_DELAY_SECOND  16'he602
`define IDX_DELAY_THIRD   16'he603
`define IDX_LINE_PERIOD   16'he607
`define IDX_COMP_MODE     16'he60e
`define IDX_POWER_SIGN    16'he617
`define IDX_ACC_MODE      16'he701
`define IDX_SAG_CYCLES    16'he704

// Field positions
`define GROUP_BIT     14
`define DSEL_HI       10
`define DSEL_LO       9
`define ASRC_BIT      6
`define RSRC_BIT      7
`define RSIGN_LO      4
`define REVA_LO       6
`define REVR_LO       10
`define SAG_FLAG_BIT  16
`define OI_FLAG_BIT   17
`define OV_FLAG_BIT   18

// Field codes and reset values
`define DSEL_CUR_CUR  2'b10
`define THR_RESET     24'hffffff
`define FULL_SCALE    24'h5a7540
`define MODE_RESET    16'h0000
`define CNT_MAX       16'hffff

// Rates
`define CLK_HZ        25'd20000000
`define TICK_HZ       25'd256000
`define SAMPLE_HZ     25'd8000

`endif

// ===== src/power_quality_monitor.v
// Purpose: overvoltage/overcurrent, power sign, reversal, delay, period
//          and sag monitoring with two active-low interrupt pins
// Assumes: samples and sign/zero-crossing inputs synchronous to clk_sys
// Notes: Avalon-MM slave, one wait cycle on every access
//
// Added by the designer: the Avalon-MM interface to the registers.
`include "pqm_consts.vh"

module power_quality_monitor #(
  parameter DW = 24,
  parameter CW = 16
) (
  input  wire              clk_sys,
  input  wire              arst_n,
  input  wire [17:0]       address,
  input  wire              read,
  input  wire              write,
  input  wire [31:0]       writedata,
  input  wire [3:0]        byteenable,
  output reg  [31:0]       readdata,
  output reg               waitrequest,
  input  wire [DW-1:0]     voltageSample,
  input  wire [6*DW-1:0]   currentSamples,
  input  wire [5:0]        activeSignTotal,
  input  wire [5:0]        activeSignAlt,
  input  wire [5:0]        reactiveSignTotal,
  input  wire [5:0]        reactiveSignAlt,
  input  wire              zxVoltageRise,
  input  wire              zxVoltageFall,
  input  wire [5:0]        zxCurrentRise,
  output reg               interrupt_pin_first_n,
  output reg               interrupt_pin_second_n
);

  // Absolute value of a signed sample
  function [DW-1:0] absVal;
    input [DW-1:0] x;
    begin
      absVal = x[DW-1] ? (~x + 1'b1) : x;
    end
  endfunction

  // Register storage
  reg  [31:0]   statusFirst_reg;
  reg  [31:0]   statusSecond_reg;
  reg  [31:0]   irqEnableFirst_reg;
  reg  [31:0]   irqEnableSecond_reg;
  reg  [DW-1:0] ovThr_reg;
  reg  [DW-1:0] oiThr_reg;
  reg  [DW-1:0] sagLevel_reg;
  reg  [15:0]   computation_mode_reg;
  reg  [7:0]    accumulation_mode_reg;
  reg  [7:0]    sagCycles_reg;
  reg  [CW-1:0] delay_reg [0:2];
  reg  [CW-1:0] period_reg;

  // Bus decode
  wire [15:0] idx   = address[17:2];
  wire        align = (address[1:0] == 2'b00);
  wire        fire  = !waitrequest;
  wire        wrEn  = write && fire && align;
  wire [31:0] bmask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                       {8{byteenable[1]}}, {8{byteenable[0]}}};
  wire [31:0] wBits = writedata & bmask;

  // Merge byte-enabled write into an old value
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [31:0] m;
    begin
      merge = (old & ~m) | (nw & m);
    end
  endfunction

  // 256 kHz tick by fractional accumulation, 8 kHz from it
  reg  [24:0] fracAcc_reg;
  reg  [4:0]  slowDiv_reg;
  reg         tick_reg;
  reg         sampleTick_reg;
  wire [24:0] fracSum = fracAcc_reg + `TICK_HZ;
  localparam [24:0] SLOW_LAST = `TICK_HZ / `SAMPLE_HZ - 25'd1;

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      fracAcc_reg    <= 25'h0;
      slowDiv_reg    <= 5'h0;
      tick_reg       <= 1'b0;
      sampleTick_reg <= 1'b0;
    end else begin
      sampleTick_reg <= 1'b0;
      if (fracSum >= `CLK_HZ) begin
        fracAcc_reg <= fracSum - `CLK_HZ;
        tick_reg    <= 1'b1;
        if ({20'h0, slowDiv_reg} == SLOW_LAST) begin
          slowDiv_reg    <= 5'h0;
          sampleTick_reg <= 1'b1;
        end else begin
          slowDiv_reg <= slowDiv_reg + 5'h1;
        end
      end else begin
        fracAcc_reg <= fracSum;
        tick_reg    <= 1'b0;
      end
    end
  end

  // Group and source selection of power sign bits
  wire       grp = computation_mode_reg[`GROUP_BIT];
  wire [1:0] dsel = computation_mode_reg[`DSEL_HI:`DSEL_LO];
  wire [5:0] actSrc = accumulation_mode_reg[`ASRC_BIT] ? activeSignAlt
                                             : activeSignTotal;
  wire [5:0] reaSrc = accumulation_mode_reg[`RSRC_BIT] ? reactiveSignAlt
                                             : reactiveSignTotal;
  wire [2:0] actSign = grp ? actSrc[5:3] : actSrc[2:0];
  wire [2:0] reaSign = grp ? reaSrc[5:3] : reaSrc[2:0];

  // Threshold compare per channel
  wire [DW-1:0] vAbs = absVal(voltageSample);
  wire ovHit = (ovThr_reg == {DW{1'b0}}) ||
               ((vAbs > ovThr_reg) && (ovThr_reg < `FULL_SCALE));
  wire [2:0] oiHits;
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : gOi
      wire [DW-1:0] raw = grp ? currentSamples[(g+3)*DW +: DW]
                              : currentSamples[g*DW +: DW];
      wire [DW-1:0] iAbs = absVal(raw);
      assign oiHits[g] = (oiThr_reg == {DW{1'b0}}) ||
                         ((iAbs > oiThr_reg) &&
                          (oiThr_reg < `FULL_SCALE));
    end
  endgenerate

  // Previous signs for reversal detection
  reg  [2:0] actPrev_reg;
  reg  [2:0] reaPrev_reg;
  reg        signSeen_reg;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      actPrev_reg  <= 3'h0;
      reaPrev_reg  <= 3'h0;
      signSeen_reg <= 1'b0;
    end else begin
      actPrev_reg  <= actSign;
      reaPrev_reg  <= reaSign;
      signSeen_reg <= 1'b1;
    end
  end
  // No false reversal on the first cycle after reset
  wire [2:0] actFlip = signSeen_reg ? (actSign ^ actPrev_reg)
                                    : 3'h0;
  wire [2:0] reaFlip = signSeen_reg ? (reaSign ^ reaPrev_reg)
                                    : 3'h0;

  // Delay start/stop sources per measurement
  wire [5:0] zc = zxCurrentRise;
  wire curMode = (dsel == `DSEL_CUR_CUR);
  wire [2:0] gzx = grp ? zc[5:3] : zc[2:0];
  reg  [2:0] startEv;
  reg  [2:0] stopEv;
  always @* begin
    startEv = {3{zxVoltageRise}};
    stopEv  = gzx;
    if (curMode) begin
      if (!grp) begin
        startEv = {zc[1], zc[0], zc[0]};
        stopEv  = {zc[2], zc[2], zc[1]};
      end else begin
        startEv = {zc[4], zc[3], zc[0]};
        stopEv  = {zc[5], zc[5], zc[4]};
      end
    end
  end

  // Delay counters on 256 kHz ticks
  reg [CW-1:0] dCnt_reg [0:2];
  reg [2:0]    dRun_reg;
  integer k;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dRun_reg <= 3'h0;
      for (k = 0; k < 3; k = k + 1) begin
        dCnt_reg[k]  <= {CW{1'b0}};
        delay_reg[k] <= {CW{1'b0}};
      end
    end else begin
      for (k = 0; k < 3; k = k + 1) begin
        if (dRun_reg[k] && stopEv[k]) begin
          delay_reg[k] <= dCnt_reg[k];
          dRun_reg[k]  <= 1'b0;
        end else if (startEv[k]) begin
          dCnt_reg[k] <= {CW{1'b0}};
          dRun_reg[k] <= 1'b1;
        end else if (dRun_reg[k] && tick_reg &&
                     dCnt_reg[k] != `CNT_MAX) begin
          dCnt_reg[k] <= dCnt_reg[k] + 1'b1;
        end
      end
    end
  end

  // Line period between voltage rising crossings
  reg [CW-1:0] pCnt_reg;
  reg          pSeen_reg;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pCnt_reg   <= {CW{1'b0}};
      pSeen_reg  <= 1'b0;
      period_reg <= {CW{1'b0}};
    end else if (zxVoltageRise) begin
      pSeen_reg <= 1'b1;
      pCnt_reg  <= {CW{1'b0}};
      if (pSeen_reg) begin
        period_reg <= (pCnt_reg == {CW{1'b0}}) ? {CW{1'b0}}
                                               : pCnt_reg - 1'b1;
      end
    end else if (tick_reg && pCnt_reg != `CNT_MAX) begin
      pCnt_reg <= pCnt_reg + 1'b1;
    end
  end

  // Sag detection over half line cycles
  reg  [7:0] sagCnt_reg;
  reg        halfLow_reg;
  wire sagOn = (sagCycles_reg != 8'h0) &&
               (sagLevel_reg != {DW{1'b0}});
  wire halfEnd = zxVoltageRise || zxVoltageFall;
  wire sagEvent = sagOn && halfEnd && halfLow_reg &&
                  (sagCnt_reg + 8'h1 >= sagCycles_reg);
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sagCnt_reg  <= 8'h0;
      halfLow_reg <= 1'b1;
    end else if (!sagOn) begin
      sagCnt_reg  <= 8'h0;
      halfLow_reg <= 1'b1;
    end else if (halfEnd) begin
      halfLow_reg <= 1'b1;
      if (!halfLow_reg || sagEvent)
        sagCnt_reg <= 8'h0;
      else
        sagCnt_reg <= sagCnt_reg + 8'h1;
    end else if (sampleTick_reg && !(vAbs < sagLevel_reg)) begin
      halfLow_reg <= 1'b0;
    end
  end

  // Events into status bits, set wins over write-one-clear
  wire [31:0] setFirst = ({29'h0, actFlip} << `REVA_LO) |
                         ({29'h0, reaFlip} << `REVR_LO);
  wire [31:0] setSecond =
    ({31'h0, sampleTick_reg && ovHit} << `OV_FLAG_BIT) |
    ({31'h0, sampleTick_reg && |oiHits} << `OI_FLAG_BIT) |
    ({31'h0, sagEvent} << `SAG_FLAG_BIT);
  wire [31:0] clrFirst  = (wrEn && idx == `IDX_STATUS_FIRST)
                          ? wBits : 32'h0;
  wire [31:0] clrSecond = (wrEn && idx == `IDX_STATUS_SECOND)
                          ? wBits : 32'h0;

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      statusFirst_reg  <= 32'h0;
      statusSecond_reg <= 32'h0;
    end else begin
      statusFirst_reg  <= (statusFirst_reg & ~clrFirst) | setFirst;
      statusSecond_reg <= (statusSecond_reg & ~clrSecond) | setSecond;
    end
  end

  // Byte-lane merges, cut to each register's width
  wire [31:0] ovMerged   = merge({8'h0, ovThr_reg}, wBits, bmask);
  wire [31:0] oiMerged   = merge({8'h0, oiThr_reg}, wBits, bmask);
  wire [31:0] lvlMerged  = merge({8'h0, sagLevel_reg}, wBits, bmask);
  wire [31:0] modeMerged = merge({16'h0, computation_mode_reg}, wBits, bmask);
  wire [31:0] accMerged  = merge({24'h0, accumulation_mode_reg}, wBits, bmask);
  wire [31:0] cycMerged  = merge({24'h0, sagCycles_reg}, wBits, bmask);

  // Writable configuration registers
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irqEnableFirst_reg  <= 32'h0;
      irqEnableSecond_reg <= 32'h0;
      ovThr_reg           <= `THR_RESET;
      oiThr_reg           <= `THR_RESET;
      sagLevel_reg        <= {DW{1'b0}};
      computation_mode_reg        <= `MODE_RESET;
      accumulation_mode_reg         <= 8'h0;
      sagCycles_reg       <= 8'h0;
    end else if (wrEn) begin
      case (idx)
        `IDX_IRQ_EN_FIRST: irqEnableFirst_reg <=
          merge(irqEnableFirst_reg, wBits, bmask);
        `IDX_IRQ_EN_SECOND: irqEnableSecond_reg <=
          merge(irqEnableSecond_reg, wBits, bmask);
        `IDX_OV_THR:     ovThr_reg     <= ovMerged[DW-1:0];
        `IDX_OI_THR:     oiThr_reg     <= oiMerged[DW-1:0];
        `IDX_SAG_LEVEL:  sagLevel_reg  <= lvlMerged[DW-1:0];
        `IDX_COMP_MODE:  computation_mode_reg  <= modeMerged[15:0];
        `IDX_ACC_MODE:   accumulation_mode_reg   <= accMerged[7:0];
        `IDX_SAG_CYCLES: sagCycles_reg <= cycMerged[7:0];
        default: ;
      endcase
    end
  end

  // Read multiplexer, unmapped reads return zero
  reg [31:0] rdMux;
  always @* begin
    rdMux = 32'h0;
    if (align) begin
      case (idx)
        `IDX_STATUS_FIRST:  rdMux = statusFirst_reg;
        `IDX_STATUS_SECOND: rdMux = statusSecond_reg;
        `IDX_OI_THR:        rdMux = {8'h0, oiThr_reg};
        `IDX_OV_THR:        rdMux = {8'h0, ovThr_reg};
        `IDX_SAG_LEVEL:     rdMux = {8'h0, sagLevel_reg};
        `IDX_IRQ_EN_FIRST:  rdMux = irqEnableFirst_reg;
        `IDX_IRQ_EN_SECOND: rdMux = irqEnableSecond_reg;
        `IDX_DELAY_FIRST:   rdMux = {16'h0, delay_reg[0]};
        `IDX_DELAY_SECOND:  rdMux = {16'h0, delay_reg[1]};
        `IDX_DELAY_THIRD:   rdMux = {16'h0, delay_reg[2]};
        `IDX_LINE_PERIOD:   rdMux = {16'h0, period_reg};
        `IDX_COMP_MODE:     rdMux = {16'h0, computation_mode_reg};
        `IDX_POWER_SIGN:    rdMux = {25'h0, reaSign, 1'b0,
                                     actSign};
        `IDX_ACC_MODE:      rdMux = {24'h0, accumulation_mode_reg};
        `IDX_SAG_CYCLES:    rdMux = {24'h0, sagCycles_reg};
        default:            rdMux = 32'h0;
      endcase
    end
  end

  // Avalon handshake: one wait cycle, then completion
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0;
    end else if ((read || write) && waitrequest) begin
      waitrequest <= 1'b0;
      if (read)
        readdata <= rdMux;
    end else begin
      waitrequest <= 1'b1;
    end
  end

  // Interrupt pins follow enabled status flags
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      interrupt_pin_first_n  <= 1'b1;
      interrupt_pin_second_n <= 1'b1;
    end else begin
      interrupt_pin_first_n  <=
        ~|(statusFirst_reg & irqEnableFirst_reg);
      interrupt_pin_second_n <=
        ~|(statusSecond_reg & irqEnableSecond_reg);
    end
  end

endmodule // power_quality_monitor

// ===== dv/pqm_host.sv
// Purpose: host-side bus master for the monitor registers
// Assumes: Avalon-MM slave with waitrequest
// Notes: request changes only by non-blocking assignment after an edge
`include "pqm_consts.vh"
module pqm_host (
  input  wire logic        clk_sys,
  output logic      [17:0] address,
  output logic             read,
  output logic             write,
  output logic      [31:0] writedata,
  output logic      [3:0]  byteenable,
  input  wire logic [31:0] readdata,
  input  wire logic        waitrequest
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus at time zero
  initial begin
    address    = 18'h0;
    read       = 1'b0;
    write      = 1'b0;
    writedata  = 32'h0;
    byteenable = 4'hf;
  end
  // One access, held until waitrequest is seen low
  task automatic xfer(input logic wr, input logic [15:0] idx,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    address   <= {idx, 2'b00};
    writedata <= d;
    read      <= !wr;
    write     <= wr;
    do @(posedge clk_sys);
    while (waitrequest !== 1'b0);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask
  // Level zeroed first so the sag count restarts and never spans two settings
  task automatic setSag(input logic [23:0] lvl, input logic [7:0] cyc);
    logic [31:0] q;
    xfer(1'b1, `IDX_SAG_LEVEL, 32'h0, q);
    xfer(1'b1, `IDX_SAG_CYCLES, {24'h0, cyc}, q);
    xfer(1'b1, `IDX_SAG_LEVEL, {8'h0, lvl}, q);
  endtask
endmodule // pqm_host

// ===== dv/power_quality_monitor_assertions.sv
// Purpose: port-level checks for the power quality monitor
// Assumes: one clock, asynchronous active-low reset
// Notes: bound to every monitor instance
`include "pqm_consts.vh"
module power_quality_monitor_assertions (
  input wire logic        clk_sys,
  input wire logic        arst_n,
  input wire logic [17:0] address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic [5:0]  activeSignTotal,
  input wire logic [5:0]  activeSignAlt,
  input wire logic [5:0]  reactiveSignTotal,
  input wire logic [5:0]  reactiveSignAlt,
  input wire logic        interrupt_pin_first_n,
  input wire logic        interrupt_pin_second_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  logic [23:0] signPrev;
  logic [2:0]  recent;
  wire  [23:0] signNow = {activeSignTotal, activeSignAlt,
                          reactiveSignTotal, reactiveSignAlt};
  wire         wrDone = write && !waitrequest;
  wire         rdTake = read && waitrequest;
  // Recent sign change or completed write
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      signPrev <= 24'h0;
      recent   <= 3'h0;
    end else begin
      signPrev <= signNow;
      recent   <= {recent[1:0], (signNow != signPrev) || wrDone};
    end
  end
  property p_wait_one; !waitrequest |=> waitrequest; endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait low twice");
  property p_answer; (read || write) && waitrequest |=> !waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  property p_cause; $fell(waitrequest) |-> $past(read || write); endproperty
  a_cause: assert property (p_cause) else $error("answer without request");
  property p_hold; !rdTake |=> $stable(readdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_sign; rdTake && address == {`IDX_POWER_SIGN, 2'b00}
    |=> readdata[31:7] == 25'h0 && !readdata[3]; endproperty
  a_sign: assert property (p_sign) else $error("sign spare bits");
  property p_width; rdTake && address >= {`IDX_DELAY_FIRST, 2'b00}
    && address <= {`IDX_LINE_PERIOD, 2'b00} |=> readdata[31:16] == 16'h0;
  endproperty
  a_width: assert property (p_width) else $error("count too wide");
  property p_first; $fell(interrupt_pin_first_n) |-> |recent; endproperty
  a_first: assert property (p_first) else $error("pin one fell");
  property p_release; $rose(interrupt_pin_second_n)
    |-> $past(wrDone) || $past(wrDone, 2); endproperty
  a_release: assert property (p_release) else $error("pin two rose");
  c_first: cover property ($fell(interrupt_pin_first_n));
  c_second: cover property ($fell(interrupt_pin_second_n));
  c_sign: cover property (rdTake && address == {`IDX_POWER_SIGN, 2'b00});
endmodule // power_quality_monitor_assertions

bind power_quality_monitor power_quality_monitor_assertions chk (
  .clk_sys, .arst_n, .address, .read, .write, .readdata, .waitrequest,
  .activeSignTotal, .activeSignAlt, .reactiveSignTotal, .reactiveSignAlt,
  .interrupt_pin_first_n, .interrupt_pin_second_n);

// ===== dv/power_quality_monitor_tb.sv
// Purpose: self-checking bench for the power quality monitor
// Assumes: host model drives the register bus
// Notes: random signs plus hand-picked threshold and sag cases
`include "pqm_consts.vh"
module power_quality_monitor_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic         clk_sys = 1'b0;
  logic         arst_n = 1'b0;
  logic [17:0]  address;
  logic         read, write, waitrequest;
  logic [31:0]  writedata, readdata, q;
  logic [3:0]   byteenable;
  logic [23:0]  voltageSample = 24'h0;
  logic [143:0] currentSamples = 144'h0;
  logic [5:0]   activeSignTotal = 6'h0, activeSignAlt = 6'h0;
  logic [5:0]   reactiveSignTotal = 6'h0, reactiveSignAlt = 6'h0;
  logic [5:0]   zxCurrentRise = 6'h0;
  logic         zxVoltageRise = 1'b0, zxVoltageFall = 1'b0;
  logic         interrupt_pin_first_n, interrupt_pin_second_n;
  logic [31:0]  seed = 32'h0001204a;
  int           errCount = 0, nChecks = 0;
  // System clock
  always #25 clk_sys = ~clk_sys;
  power_quality_monitor uut (.clk_sys, .arst_n, .address, .read, .write,
    .writedata, .byteenable, .readdata, .waitrequest, .voltageSample,
    .currentSamples, .activeSignTotal, .activeSignAlt, .reactiveSignTotal,
    .reactiveSignAlt, .zxVoltageRise, .zxVoltageFall, .zxCurrentRise,
    .interrupt_pin_first_n, .interrupt_pin_second_n);
  pqm_host host (.clk_sys, .address, .read, .write, .writedata,
    .byteenable, .readdata, .waitrequest);
  function automatic logic [31:0] nextRnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] expSign(input logic g, input logic [1:0] s);
    logic [5:0] a;
    logic [5:0] r;
    a = s[0] ? activeSignAlt : activeSignTotal;
    r = s[1] ? reactiveSignAlt : reactiveSignTotal;
    return g ? {25'h0, r[5:3], 1'b0, a[5:3]} : {25'h0, r[2:0], 1'b0, a[2:0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      errCount++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [15:0] i);
    host.xfer(1'b0, i, 32'h0, q);
  endtask
  task automatic wr(input logic [15:0] i, input logic [31:0] d);
    logic [31:0] x;
    host.xfer(1'b1, i, d, x);
  endtask
  // Threshold, one sample tick, flag and pin, then restore and clear
  task automatic thr(input logic [15:0] i, input logic [23:0] v,
                     input int b, input logic hit);
    wr(i, {8'h0, v});
    repeat (2600) @(posedge clk_sys);
    rd(`IDX_STATUS_SECOND);
    chk(q[b], hit);
    chk(interrupt_pin_second_n, !hit);
    wr(i, {8'h0, `FULL_SCALE});
    repeat (2600) @(posedge clk_sys);
    wr(`IDX_STATUS_SECOND, 32'h00060000);
    repeat (2) @(posedge clk_sys);
    chk(interrupt_pin_second_n, 1'b1);
  endtask
  // Line cycles: voltage rise, current A and B rise, voltage fall
  task automatic line(input int k);
    repeat (k) begin
      zxVoltageRise <= 1'b1;
      @(posedge clk_sys);
      zxVoltageRise <= 1'b0;
      repeat (1952) @(posedge clk_sys);
      zxCurrentRise <= 6'h03;
      @(posedge clk_sys);
      zxCurrentRise <= 6'h00;
      repeat (1952) @(posedge clk_sys);
      zxVoltageFall <= 1'b1;
      @(posedge clk_sys);
      zxVoltageFall <= 1'b0;
      repeat (3905) @(posedge clk_sys);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (90000) @(posedge clk_sys);
    errCount++;
    $display("ERROR t=%0t watchdog expired", $time);
    final_report();
  end
  // Main sequence
  initial begin
    int i;
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd(`IDX_OV_THR);
    chk(q, 32'h00ffffff);
    rd(`IDX_IRQ_EN_SECOND);
    chk(q, 32'h0);
    rd(16'he5ff);
    chk(q, 32'h0);
    for (i = 0; i < 8; i++) begin
      wr(`IDX_COMP_MODE, {17'h0, i[0], 14'h0});
      wr(`IDX_ACC_MODE, {24'h0, i[2:1], 6'h0});
      q = nextRnd();
      {activeSignTotal, activeSignAlt, reactiveSignTotal,
       reactiveSignAlt} <= q[23:0];
      @(posedge clk_sys);
      rd(`IDX_POWER_SIGN);
      chk(q, expSign(i[0], i[2:1]));
    end
    wr(`IDX_COMP_MODE, 32'h0);
    wr(`IDX_ACC_MODE, 32'h0);
    wr(`IDX_STATUS_FIRST, 32'h00001dc0);
    wr(`IDX_IRQ_EN_FIRST, 32'h00000040);
    activeSignTotal[0] <= ~activeSignTotal[0];
    reactiveSignTotal[2] <= ~reactiveSignTotal[2];
    repeat (4) @(posedge clk_sys);
    chk(interrupt_pin_first_n, 1'b0);
    rd(`IDX_STATUS_FIRST);
    chk(q & 32'h00001dc0, 32'h00001040);
    wr(`IDX_STATUS_FIRST, 32'h00001040);
    reactiveSignTotal[2] <= ~reactiveSignTotal[2];
    repeat (4) @(posedge clk_sys);
    chk(interrupt_pin_first_n, 1'b1);
    rd(`IDX_STATUS_FIRST);
    chk(q & 32'h00001dc0, 32'h00001000);
    wr(`IDX_IRQ_EN_SECOND, 32'h00060000);
    voltageSample <= 24'h800001;
    thr(`IDX_OV_THR, `FULL_SCALE, 18, 1'b0);
    thr(`IDX_OV_THR, 24'h001000, 18, 1'b1);
    voltageSample <= 24'h000000;
    thr(`IDX_OV_THR, 24'h000000, 18, 1'b1);
    currentSamples[119:96] <= 24'h800100;
    thr(`IDX_OI_THR, 24'h001000, 17, 1'b0);
    wr(`IDX_COMP_MODE, 32'h00004000);
    thr(`IDX_OI_THR, 24'h001000, 17, 1'b1);
    wr(`IDX_COMP_MODE, 32'h0);
    line(2);
    rd(`IDX_LINE_PERIOD);
    chk(q >= 32'd98 && q <= 32'd100, 1'b1);
    for (i = 0; i < 2; i++) begin
      rd(`IDX_DELAY_FIRST + i[15:0]);
      chk(q >= 32'd24 && q <= 32'd26, 1'b1);
    end
    // Current-to-current delays: A, B, C rises 782 clocks apart
    wr(`IDX_COMP_MODE, 32'h00000400);
    for (i = 0; i < 3; i++) begin
      zxCurrentRise <= 6'h01 << i;
      @(posedge clk_sys);
      zxCurrentRise <= 6'h00;
      repeat (781) @(posedge clk_sys);
    end
    rd(`IDX_DELAY_FIRST);
    chk(q >= 32'd9 && q <= 32'd11, 1'b1);
    rd(`IDX_DELAY_SECOND);
    chk(q >= 32'd19 && q <= 32'd21, 1'b1);
    rd(`IDX_DELAY_THIRD);
    chk(q >= 32'd9 && q <= 32'd11, 1'b1);
    rd(`IDX_STATUS_SECOND);
    chk(q[16], 1'b0);
    host.setSag(24'h000100, 8'h02);
    line(2);
    rd(`IDX_STATUS_SECOND);
    chk(q[16], 1'b1);
    voltageSample <= 24'h000200;
    line(1);
    wr(`IDX_STATUS_SECOND, 32'h00010000);
    line(1);
    rd(`IDX_STATUS_SECOND);
    chk(q[16], 1'b0);
    final_report();
  end
endmodule // power_quality_monitor_tb
